// ==== hw/info_field_pkg.sv ====
// Constants and types shared by the service information field codec
package info_field_pkg;
   // Extension numbers of the three fields
   localparam logic [4:0] EXT_COUNTRY = 5'h09;
   localparam logic [4:0] EXT_COMPONENT = 5'h14;
   localparam logic [4:0] EXT_GENRE = 5'h11;
   // Layout figures
   localparam logic [4:0] EXT_FIELD_MAX_BYTES = 5'h19;
   localparam logic [4:0] SPECIAL_HOUR = 5'h1F;
   localparam logic [5:0] SPECIAL_MINSEC = 6'h3F;
   localparam logic [2:0] SVC_SHORT_BYTES = 3'h2;
   localparam logic [2:0] SVC_LONG_BYTES = 3'h4;
   localparam logic [2:0] ENS_BYTES = 3'h2;
   localparam logic [2:0] DATE_BYTES = 3'h3;
   localparam logic [2:0] GENRE_TAIL_BYTES = 3'h2;
   localparam logic [16:0] DATE_WRAP = 17'h00020;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   // Repetition timing
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned REPEAT_PERIOD_MS = 1000;
   localparam int unsigned REPEAT_CYCLES = CLK_HZ / 1000 * REPEAT_PERIOD_MS;
   typedef enum logic [1:0] {
      REC_COUNTRY, REC_COUNTRY_SUB, REC_COMPONENT, REC_GENRE
   } rec_kind_type;
   typedef enum logic [3:0] {
      SEG_IDLE, SEG_SKIP, SEG_C_HDR, SEG_C_ECC, SEG_C_TAB, SEG_X_HDR,
      SEG_X_ECC, SEG_X_SVC, SEG_SVC, SEG_FLAGS, SEG_DESC, SEG_DATE,
      SEG_TSVC, SEG_TENS, SEG_G_SVC, SEG_G_TAIL
   } seg_type;
endpackage

// ==== hw/info_field_codec.sv ====
// Byte-stream parser for the country, component information and genre fields
`timescale 1ns/1ns
// Functional notes
// R1: Fields chosen by extension 9, 20, 17
// R2: Extension flag says per-service extension present
// R3: Offset is sign-magnitude half hours, b5 sign
// R4: Country code and table selector are bytes
// R5: Per-service extension limited to 25 bytes
// R6: Sub-field: count, reserved, country, identifiers
// R7: Reserved bits must be zero
// R8: Each field repeats once per second
// R9: Identifiers 16 or 32 bits by P/D
// R10: 4-bit component index within service
// R11: Change code decoded into four cases
// R12: Part-time flag marks on/off cycling
// R13: Description byte present only when flagged
// R14: Description: access, audio/data, 6-bit type
// R15: Access flag set only for whole component
// R16: 5-bit date, carry inferred on wrap
// R17: Change time fields with special values
// R18: All special time values void the date
// R19: Transfer identifier flags control presence
// R20: Genre carries identifier and dynamic flag
// R21: One genre code per service entry
// R22: 5-bit genre after ten zero reserved bits
// R23: Full day count is 17 bits
// R24: One-cycle record strobe, malformed flagged
module info_field_codec
   import info_field_pkg::*;
#(
   parameter int unsigned REPEAT_CYCLES_P = REPEAT_CYCLES
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [7:0] in_data,
   input wire logic [4:0] in_ext,
   input wire logic in_pd,
   input wire logic in_last,
   output logic in_ready,
   input wire logic res_ready,
   input wire logic [16:0] today_day,
   output logic rec_valid,
   output rec_kind_type rec_kind,
   output logic rec_malformed,
   output logic ext_present,
   output logic [5:0] local_time_offset,
   output logic [5:0] half_hour_offset,
   output logic [7:0] country_code,
   output logic [7:0] intl_table_select,
   output logic [1:0] service_count,
   output logic [47:0] service_list,
   output logic [31:0] service_identifier,
   output logic [3:0] component_index,
   output logic [1:0] change_code,
   output logic [3:0] change_onehot,
   output logic part_time,
   output logic component_desc_flag,
   output logic access_control_flag,
   output logic type_is_data,
   output logic [5:0] component_type_code,
   output logic [16:0] change_day,
   output logic change_day_valid,
   output logic [4:0] change_hour,
   output logic [5:0] change_minute,
   output logic [5:0] change_second,
   output logic transfer_svc_flag,
   output logic transfer_ens_flag,
   output logic [31:0] transfer_svc,
   output logic [15:0] ensemble_identifier,
   output logic genre_dynamic,
   output logic [4:0] genre_code,
   output logic repeat_due
);
   typedef struct packed {
      logic [1:0][14:0] buf_mem;
      logic buf_wr;
      logic buf_rd;
      logic [1:0] buf_cnt;
      seg_type seg;
      logic [2:0] sub;
      logic [4:0] ext;
      logic pd;
      logic [4:0] ext_len;
      logic [23:0] scratch;
      logic bad;
      logic [24:0] rep_cnt;
      logic rep_due;
      logic rec_valid;
      rec_kind_type kind;
      logic malformed;
      logic ext_flag;
      logic [5:0] ofs;
      logic [5:0] ofs_hh;
      logic [7:0] ecc;
      logic [7:0] table_sel;
      logic [1:0] nserv;
      logic [47:0] svc_list;
      logic [31:0] svc;
      logic [3:0] comp_idx;
      logic [1:0] chg;
      logic [3:0] chg_hot;
      logic part_time;
      logic desc_flag;
      logic ac;
      logic is_data;
      logic [5:0] type_code;
      logic [16:0] day;
      logic day_valid;
      logic [4:0] hour;
      logic [5:0] minute;
      logic [5:0] second;
      logic tsvc_flag;
      logic tens_flag;
      logic [31:0] tsvc;
      logic [15:0] ens;
      logic dynamic;
      logic [4:0] genre;
   } state_type;

   state_type st_ff;
   state_type nxt_st;

   // Two-entry buffer refuses only when both slots hold a byte
   assign in_ready = (st_ff.buf_cnt != BUF_DEPTH);

   always_comb begin
      logic [14:0] ent;
      logic take;
      logic push;
      logic last;
      logic fin;
      logic bad;
      logic [7:0] b;
      logic [4:0] ext;
      logic pd;
      logic [2:0] sub;
      logic [2:0] svc_len;
      logic [23:0] w;
      logic [16:0] base;
      seg_type cur;
      seg_type nseg;
      seg_type entry_seg;
      rec_kind_type kind;
      ent = st_ff.buf_mem[st_ff.buf_rd];
      take = (st_ff.buf_cnt != 2'h0) && res_ready;
      push = in_valid && in_ready;
      last = ent[14];
      b = ent[7:0];
      fin = 1'b0;
      bad = st_ff.bad;
      ext = st_ff.ext;
      pd = st_ff.pd;
      sub = st_ff.sub;
      w = {st_ff.scratch[15:0], b};
      base = 17'h00000;
      cur = st_ff.seg;
      entry_seg = SEG_SKIP;
      kind = REC_COUNTRY;
      svc_len = SVC_SHORT_BYTES;
      nseg = st_ff.seg;
      nxt_st = st_ff;
      nxt_st.rec_valid = 1'b0;
      nxt_st.rep_due = 1'b0;

      // Once-per-second repetition tick for the assembling side
      if (st_ff.rep_cnt == 25'(REPEAT_CYCLES_P - 1)) begin
         nxt_st.rep_cnt = 25'h0000000; // R8
         nxt_st.rep_due = 1'b1;
      end else begin
         nxt_st.rep_cnt = st_ff.rep_cnt + 25'h0000001;
      end

      // Buffer bookkeeping; a stalled parser leaves bytes in place
      if (push) begin
         nxt_st.buf_mem[st_ff.buf_wr] = {in_last, in_pd, in_ext, in_data};
         nxt_st.buf_wr = ~st_ff.buf_wr;
      end
      if (take) begin
         nxt_st.buf_rd = ~st_ff.buf_rd;
      end
      nxt_st.buf_cnt = st_ff.buf_cnt + {1'b0, push} - {1'b0, take};

      if (take) begin
         // First byte of a field picks the layout
         if (st_ff.seg == SEG_IDLE) begin
            ext = ent[12:8];
            pd = ent[13];
            sub = 3'h0;
            bad = 1'b0;
            nxt_st.ext_len = 5'h00;
            case (ext)
               EXT_COUNTRY: cur = SEG_C_HDR; // R1
               EXT_COMPONENT: cur = SEG_SVC; // R1
               EXT_GENRE: cur = SEG_G_SVC; // R1
               default: cur = SEG_SKIP;
            endcase
         end
         nxt_st.ext = ext;
         nxt_st.pd = pd;
         svc_len = pd ? SVC_LONG_BYTES : SVC_SHORT_BYTES; // R9
         nseg = cur;
         case (cur)
            SEG_C_HDR: begin
               nxt_st.ext_flag = b[7]; // R2
               bad = bad | b[6]; // R7
               nxt_st.ofs = b[5:0];
               nxt_st.ofs_hh = b[5] ? 6'(-{1'b0, b[4:0]}) : {1'b0, b[4:0]}; // R3
               nseg = SEG_C_ECC;
            end
            SEG_C_ECC: begin
               nxt_st.ecc = b; // R4
               nseg = SEG_C_TAB;
            end
            SEG_C_TAB: begin
               nxt_st.table_sel = b; // R4
               fin = 1'b1;
               bad = bad | (st_ff.ext_flag == last); // R2
               entry_seg = st_ff.ext_flag ? SEG_X_HDR : SEG_SKIP;
            end
            SEG_X_HDR: begin
               nxt_st.nserv = b[7:6]; // R6
               bad = bad | (b[5:0] != 6'h00); // R7
               nxt_st.svc_list = 48'h000000000000;
               nseg = SEG_X_ECC;
            end
            SEG_X_ECC: begin
               nxt_st.ecc = b; // R6
               fin = (st_ff.nserv == 2'h0);
               nseg = SEG_X_SVC;
               entry_seg = SEG_X_HDR;
            end
            SEG_X_SVC: begin
               nxt_st.svc_list = {st_ff.svc_list[39:0], b}; // R6
               // Two bytes per listed service, so the last index is 2n-1
               fin = (sub == {st_ff.nserv, 1'b0} - 3'h1);
               entry_seg = SEG_X_HDR;
            end
            SEG_SVC, SEG_G_SVC: begin
               nxt_st.svc = (sub == 3'h0) ? {24'h000000, b} : {st_ff.svc[23:0], b};
               if (cur == SEG_G_SVC && sub == SVC_SHORT_BYTES - 3'h1) begin
                  nseg = SEG_G_TAIL; // R20
               end else if (cur == SEG_SVC && sub == svc_len - 3'h1) begin
                  nseg = SEG_FLAGS; // R9
               end
            end
            SEG_FLAGS: begin
               nxt_st.comp_idx = b[7:4]; // R10
               nxt_st.chg = b[3:2];
               nxt_st.chg_hot = 4'h1 << b[3:2]; // R11
               nxt_st.part_time = b[1]; // R12
               nxt_st.desc_flag = b[0];
               nxt_st.ac = 1'b0;
               nxt_st.is_data = 1'b0;
               nxt_st.type_code = 6'h00;
               nxt_st.tsvc = 32'h00000000;
               nxt_st.ens = 16'h0000;
               nseg = b[0] ? SEG_DESC : SEG_DATE; // R13
            end
            SEG_DESC: begin
               nxt_st.ac = b[7]; // R15
               nxt_st.is_data = b[6]; // R14
               nxt_st.type_code = b[5:0]; // R14
               nseg = SEG_DATE;
            end
            SEG_DATE: begin
               nxt_st.scratch = w;
               if (sub == DATE_BYTES - 3'h1) begin
                  // Date is the low end of the day count; wrap means a carry
                  base = {today_day[16:5], w[23:19]}; // R23
                  if (w[23:19] < today_day[4:0]) begin
                     base = base + DATE_WRAP; // R16
                  end
                  nxt_st.day = base;
                  nxt_st.hour = w[18:14]; // R17
                  nxt_st.minute = w[13:8];
                  nxt_st.second = w[7:2];
                  nxt_st.day_valid = !(w[18:14] == SPECIAL_HOUR && w[13:8] == SPECIAL_MINSEC
                     && w[7:2] == SPECIAL_MINSEC); // R18
                  nxt_st.tsvc_flag = w[1]; // R19
                  nxt_st.tens_flag = w[0]; // R19
                  if (w[1]) begin
                     nseg = SEG_TSVC;
                  end else if (w[0]) begin
                     nseg = SEG_TENS;
                  end else begin
                     fin = 1'b1;
                  end
               end
               entry_seg = SEG_SVC;
            end
            SEG_TSVC: begin
               nxt_st.tsvc = {st_ff.tsvc[23:0], b}; // R9
               if (sub == svc_len - 3'h1) begin
                  if (st_ff.tens_flag) begin
                     nseg = SEG_TENS;
                  end else begin
                     fin = 1'b1;
                  end
               end
               entry_seg = SEG_SVC;
            end
            SEG_TENS: begin
               nxt_st.ens = {st_ff.ens[7:0], b}; // R19
               fin = (sub == ENS_BYTES - 3'h1);
               entry_seg = SEG_SVC;
            end
            SEG_G_TAIL: begin
               nxt_st.scratch = w;
               if (sub == GENRE_TAIL_BYTES - 3'h1) begin
                  nxt_st.dynamic = w[15]; // R20
                  bad = bad | (w[14:5] != 10'h000); // R22
                  nxt_st.genre = w[4:0]; // R21
                  fin = 1'b1;
               end
               entry_seg = SEG_G_SVC;
            end
            default: begin
               nseg = SEG_SKIP;
            end
         endcase

         // Extended part of the country field is bounded in length
         if (cur == SEG_X_HDR || cur == SEG_X_ECC || cur == SEG_X_SVC) begin
            bad = bad | (st_ff.ext_len == EXT_FIELD_MAX_BYTES); // R5
            nxt_st.ext_len = (st_ff.ext_len == EXT_FIELD_MAX_BYTES) ?
               st_ff.ext_len : st_ff.ext_len + 5'h01;
         end

         // Record kind follows the segment that ends it
         case (cur)
            SEG_C_HDR, SEG_C_ECC, SEG_C_TAB: kind = REC_COUNTRY;
            SEG_X_HDR, SEG_X_ECC, SEG_X_SVC: kind = REC_COUNTRY_SUB;
            SEG_G_SVC, SEG_G_TAIL: kind = REC_GENRE;
            default: kind = REC_COMPONENT;
         endcase

         // Strobe on each finished entry or on a field cut short
         if (cur != SEG_SKIP && (fin || last)) begin
            nxt_st.rec_valid = 1'b1; // R24
            nxt_st.kind = kind;
            nxt_st.malformed = bad | !fin; // R24
            bad = 1'b0;
         end
         nxt_st.bad = bad;
         if (last) begin
            nseg = SEG_IDLE;
         end else if (fin) begin
            nseg = entry_seg;
         end
         nxt_st.sub = (nseg == cur && !fin) ? sub + 3'h1 : 3'h0;
         nxt_st.seg = nseg;
      end
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from the state register
   assign rec_valid = st_ff.rec_valid;
   assign rec_kind = st_ff.kind;
   assign rec_malformed = st_ff.malformed;
   assign ext_present = st_ff.ext_flag;
   assign local_time_offset = st_ff.ofs;
   assign half_hour_offset = st_ff.ofs_hh;
   assign country_code = st_ff.ecc;
   assign intl_table_select = st_ff.table_sel;
   assign service_count = st_ff.nserv;
   assign service_list = st_ff.svc_list;
   assign service_identifier = st_ff.svc;
   assign component_index = st_ff.comp_idx;
   assign change_code = st_ff.chg;
   assign change_onehot = st_ff.chg_hot;
   assign part_time = st_ff.part_time;
   assign component_desc_flag = st_ff.desc_flag;
   assign access_control_flag = st_ff.ac;
   assign type_is_data = st_ff.is_data;
   assign component_type_code = st_ff.type_code;
   assign change_day = st_ff.day;
   assign change_day_valid = st_ff.day_valid;
   assign change_hour = st_ff.hour;
   assign change_minute = st_ff.minute;
   assign change_second = st_ff.second;
   assign transfer_svc_flag = st_ff.tsvc_flag;
   assign transfer_ens_flag = st_ff.tens_flag;
   assign transfer_svc = st_ff.tsvc;
   assign ensemble_identifier = st_ff.ens;
   assign genre_dynamic = st_ff.dynamic;
   assign genre_code = st_ff.genre;
   assign repeat_due = st_ff.rep_due;

   // Checks on the parser's outputs
   property p_kind_ext;
      @(posedge clk_sys) disable iff (rst)
      rec_valid && rec_kind == REC_COMPONENT |-> st_ff.ext == EXT_COMPONENT;
   endproperty
   a_kind_ext: assert property (p_kind_ext) else $error("component record from wrong field"); // R1
   property p_ofs;
      @(posedge clk_sys) disable iff (rst)
      rec_valid && rec_kind == REC_COUNTRY |-> (local_time_offset[5] ?
         half_hour_offset == 6'(-{1'b0, local_time_offset[4:0]}) :
         half_hour_offset == {1'b0, local_time_offset[4:0]});
   endproperty
   a_ofs: assert property (p_ofs) else $error("offset sign handling wrong"); // R3
   property p_ext_len;
      @(posedge clk_sys) disable iff (rst)
      rec_valid && rec_kind == REC_COUNTRY_SUB && st_ff.ext_len == EXT_FIELD_MAX_BYTES
         && $past(st_ff.ext_len) == EXT_FIELD_MAX_BYTES |-> rec_malformed;
   endproperty
   a_ext_len: assert property (p_ext_len) else $error("overlong extension not flagged"); // R5
   property p_repeat;
      @(posedge clk_sys) disable iff (rst)
      repeat_due |-> $past(st_ff.rep_cnt) == 25'(REPEAT_CYCLES_P - 1);
   endproperty
   a_repeat: assert property (p_repeat) else $error("repeat tick at wrong count"); // R8
   property p_change;
      @(posedge clk_sys) disable iff (rst)
      rec_valid && rec_kind == REC_COMPONENT |-> change_onehot == (4'h1 << change_code);
   endproperty
   a_change: assert property (p_change) else $error("change code decode wrong"); // R11
   property p_desc;
      @(posedge clk_sys) disable iff (rst)
      rec_valid && rec_kind == REC_COMPONENT && !component_desc_flag
         |-> !access_control_flag && component_type_code == 6'h00;
   endproperty
   a_desc: assert property (p_desc) else $error("absent description leaked"); // R14
   property p_date;
      @(posedge clk_sys) disable iff (rst)
      rec_valid && rec_kind == REC_COMPONENT && !rec_malformed
         |-> 17'(change_day - $past(today_day, 2)) < DATE_WRAP;
   endproperty
   a_date: assert property (p_date) else $error("change day not ahead of today"); // R16
   property p_special;
      @(posedge clk_sys) disable iff (rst)
      rec_valid && change_hour == SPECIAL_HOUR && change_minute == SPECIAL_MINSEC
         && change_second == SPECIAL_MINSEC && rec_kind == REC_COMPONENT
         |-> !change_day_valid;
   endproperty
   a_special: assert property (p_special) else $error("special time kept date"); // R18
   property p_strobe;
      @(posedge clk_sys) disable iff (rst)
      rec_valid |=> !rec_valid;
   endproperty
   a_strobe: assert property (p_strobe) else $error("record strobe longer than one cycle"); // R24
endmodule

// ==== tb/field_source.sv ====
// Byte source standing in for the information group multiplexer
`timescale 1ns/1ns
module field_source (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   input wire logic in_ready,
   output logic in_valid,
   output logic [7:0] in_data,
   output logic [4:0] in_ext,
   output logic in_pd,
   output logic in_last
);
   logic [14:0] fifo_q[$];
   logic [14:0] cur;

   // Queue one byte with its extension number, P/D flag and closing mark
   task automatic push(input logic [7:0] b, input logic [4:0] e, input logic p, input logic l);
      fifo_q.push_back({b, e, p, l});
   endtask

   // Hold each byte until taken; slow mode leaves a gap after every byte
   // Idle data and extension lines keep toggling so a stale byte can never look valid
   always @(posedge clk_sys) begin
      if (rst) begin
         in_valid <= 1'h0;
      end else if (!in_valid || in_ready) begin
         if (fifo_q.size() > 0 && !(slow && in_valid)) begin
            cur = fifo_q.pop_front();
            in_valid <= 1'h1;
            {in_data, in_ext, in_pd, in_last} <= cur;
         end else begin
            in_valid <= 1'h0;
            in_data <= ~in_data;
            in_ext <= ~in_ext;
            in_last <= 1'h0;
         end
      end
   end
endmodule

// ==== tb/info_field_codec_tb_top.sv ====
// Self-checking bench for the information field parser
`timescale 1ns/1ns
module info_field_codec_tb_top;
   import info_field_pkg::*;
   typedef struct packed {
      logic [4:0] ext;
      logic pd;
      logic [4:0] n;
      logic [127:0] bytes;
      rec_kind_type kind;
      logic bad;
      logic [63:0] exp;
   } row_type;
   // Short repeat period keeps the tick test brief
   localparam int unsigned PERIOD = 16;
   logic clk_sys, rst, res_ready, slow, in_valid, in_pd, in_last, in_ready;
   logic [7:0] in_data, country_code, intl_table_select;
   logic [4:0] in_ext, change_hour, genre_code;
   logic [16:0] today_day, change_day;
   logic rec_valid, rec_malformed, ext_present, part_time, component_desc_flag;
   logic access_control_flag, type_is_data, change_day_valid, transfer_svc_flag;
   logic transfer_ens_flag, genre_dynamic, repeat_due;
   rec_kind_type rec_kind;
   logic [5:0] local_time_offset, half_hour_offset, component_type_code, change_minute;
   logic [5:0] change_second;
   logic [1:0] service_count, change_code;
   logic [47:0] service_list;
   logic [31:0] service_identifier, transfer_svc;
   logic [3:0] component_index, change_onehot;
   logic [15:0] ensemble_identifier;
   row_type rows[8];
   int bad_count, compares, n;

   info_field_codec #(.REPEAT_CYCLES_P(PERIOD)) i_info_field_codec (.clk_sys, .rst, .in_valid,
      .in_data, .in_ext, .in_pd, .in_last, .in_ready, .res_ready, .today_day, .rec_valid,
      .rec_kind, .rec_malformed, .ext_present, .local_time_offset, .half_hour_offset,
      .country_code, .intl_table_select, .service_count, .service_list, .service_identifier,
      .component_index, .change_code, .change_onehot, .part_time, .component_desc_flag,
      .access_control_flag, .type_is_data, .component_type_code, .change_day,
      .change_day_valid, .change_hour, .change_minute, .change_second, .transfer_svc_flag,
      .transfer_ens_flag, .transfer_svc, .ensemble_identifier, .genre_dynamic, .genre_code,
      .repeat_due);
   field_source i_field_source (.clk_sys, .rst, .slow, .in_ready, .in_valid, .in_data,
      .in_ext, .in_pd, .in_last);

   initial begin
      clk_sys = 1'h0;
      forever #20 clk_sys = ~clk_sys;
   end

   // Record contents packed per kind; unused list slots masked by the count
   function automatic logic [63:0] obs();
      case (rec_kind)
         REC_COUNTRY: obs = {ext_present, local_time_offset, half_hour_offset, country_code,
            intl_table_select};
         REC_COUNTRY_SUB: obs = {service_count, country_code,
            service_list & ~(48'hFFFF_FFFF_FFFF << (16 * service_count))};
         REC_COMPONENT: obs = {service_identifier[15:0], component_index, change_onehot,
            change_code, part_time, component_desc_flag,
            access_control_flag & component_desc_flag, type_is_data & component_desc_flag,
            component_type_code, change_hour, change_minute, change_second, change_day_valid,
            transfer_svc_flag, transfer_ens_flag};
         default: obs = {service_identifier, genre_dynamic, genre_code};
      endcase
   endfunction

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Bytes go out first-sent first; l marks the final one as closing the field
   task automatic send(input logic [4:0] e, input logic p, input int n, input logic [127:0] b,
      input logic l);
      for (int i = 0; i < n; i++) begin
         i_field_source.push(b[8 * (n - 1 - i) +: 8], e, p, l && (i == n - 1));
      end
   endtask

   // Bounded wait for the next one-cycle record strobe
   task automatic wait_rec();
      int i;
      i = 0;
      @(posedge clk_sys);
      #1;
      while (rec_valid !== 1'h1 && i < 300) begin
         @(posedge clk_sys);
         #1;
         i++;
      end
      check({63'h0, rec_valid}, 64'h1);
   endtask

   task automatic check_rec(input rec_kind_type k, input logic b, input logic [63:0] e,
      input logic full);
      wait_rec();
      check({61'h0, rec_kind, rec_malformed}, {61'h0, k, b});
      if (full) begin
         check(obs(), e);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      close_out();
   end

   initial begin
      rst = 1'h1;
      res_ready = 1'h1;
      slow = 1'h0;
      today_day = 17'h0E001;
      bad_count = 0;
      compares = 0;
      // Ordinary fields: bytes beside the record they should give
      rows[0] = '{EXT_GENRE, 1'h0, 5'h4, 32'h1234_800C, REC_GENRE, 1'h0,
         {32'h1234, 1'h1, 5'h0C}};
      rows[1] = '{EXT_GENRE, 1'h0, 5'h4, 32'hABCD_001F, REC_GENRE, 1'h0,
         {32'hABCD, 1'h0, 5'h1F}};
      rows[2] = '{EXT_COUNTRY, 1'h0, 5'h3, 24'h23E101, REC_COUNTRY, 1'h0,
         {1'h0, 6'h23, 6'h3D, 8'hE1, 8'h01}};
      rows[3] = '{EXT_COUNTRY, 1'h0, 5'h3, 24'h1F4002, REC_COUNTRY, 1'h0,
         {1'h0, 6'h1F, 6'h1F, 8'h40, 8'h02}};
      rows[4] = '{EXT_COMPONENT, 1'h0, 5'h7, 56'h4321_57FC_1B1E00, REC_COMPONENT, 1'h0,
         {16'h4321, 4'h5, 4'h2, 2'h1, 4'hF, 6'h3C, 5'h0C, 6'h1E, 6'h00, 3'h4}};
      rows[5] = '{EXT_COMPONENT, 1'h0, 5'h6, 48'h5555_A807_FFFC, REC_COMPONENT, 1'h0,
         {16'h5555, 4'hA, 4'h4, 2'h2, 4'h0, 6'h00, 5'h1F, 6'h3F, 6'h3F, 3'h0}};
      rows[6] = '{EXT_COMPONENT, 1'h0, 5'h6, 48'h0777_321B_1E00, REC_COMPONENT, 1'h0,
         {16'h0777, 4'h3, 4'h1, 2'h0, 4'h8, 6'h00, 5'h0C, 6'h1E, 6'h00, 3'h4}};
      rows[7] = '{EXT_COMPONENT, 1'h0, 5'h6, 48'h0888_FC1B_1E00, REC_COMPONENT, 1'h0,
         {16'h0888, 4'hF, 4'h8, 2'h3, 4'h0, 6'h00, 5'h0C, 6'h1E, 6'h00, 3'h4}};
      repeat (8) @(posedge clk_sys);
      rst <= 1'h0;
      for (int i = 0; i < 8; i++) begin
         slow <= i[0];
         send(rows[i].ext, rows[i].pd, rows[i].n, rows[i].bytes, 1'h1);
         check_rec(rows[i].kind, rows[i].bad, rows[i].exp, 1'h1);
      end
      // Change day carry with today's low bits below and above the date
      for (int i = 0; i < 2; i++) begin
         today_day <= i ? 17'h0E01E : 17'h0E001;
         send(EXT_COMPONENT, 1'h0, 7, rows[4].bytes, 1'h1);
         check_rec(REC_COMPONENT, 1'h0, rows[4].exp, 1'h1);
         check({47'h0, change_day}, i ? 64'h0E023 : 64'h0E003);
      end
      // Long identifiers with both transfer fields present
      send(EXT_COMPONENT, 1'h1, 15, 120'h12345678_1105_1B1E03_0BADF00D_BEEF, 1'h1);
      check_rec(REC_COMPONENT, 1'h0, 64'h0, 1'h0);
      check({service_identifier, transfer_svc}, 64'h12345678_0BADF00D);
      check({ensemble_identifier, transfer_svc_flag, transfer_ens_flag, type_is_data,
         access_control_flag, component_type_code}, {16'hBEEF, 4'hC, 6'h05});
      // Country field with two sub-fields
      send(EXT_COUNTRY, 1'h0, 11, 88'h82E200_80D311112222_00D4, 1'h1);
      check_rec(REC_COUNTRY, 1'h0, {1'h1, 6'h02, 6'h02, 8'hE2, 8'h00}, 1'h1);
      check_rec(REC_COUNTRY_SUB, 1'h0, {2'h2, 8'hD3, 48'h0000_1111_2222}, 1'h1);
      check_rec(REC_COUNTRY_SUB, 1'h0, {2'h0, 8'hD4, 48'h0}, 1'h1);
      // Presence flag disagreeing with length, reserved bit set, short field
      send(EXT_COUNTRY, 1'h0, 3, 24'h820100, 1'h1);
      check_rec(REC_COUNTRY, 1'h1, 64'h0, 1'h0);
      send(EXT_COUNTRY, 1'h0, 5, 40'h02010000_55, 1'h1);
      check_rec(REC_COUNTRY, 1'h1, 64'h0, 1'h0);
      send(EXT_GENRE, 1'h0, 4, 32'h0001_4005, 1'h1);
      check_rec(REC_GENRE, 1'h1, {32'h1, 1'h0, 5'h05}, 1'h1);
      send(EXT_GENRE, 1'h0, 3, 24'h000280, 1'h1);
      check_rec(REC_GENRE, 1'h1, 64'h0, 1'h0);
      // Unknown extension is drained without a record
      send(5'h05, 1'h0, 5, 40'h01020304_05, 1'h1);
      send(EXT_GENRE, 1'h0, 4, rows[0].bytes, 1'h1);
      check_rec(REC_GENRE, 1'h0, rows[0].exp, 1'h1);
      // Extension of 28 bytes: the sub-field crossing 25 bytes is flagged
      send(EXT_COUNTRY, 1'h0, 3, 24'h804400, 1'h0);
      for (int i = 0; i < 7; i++) send(EXT_COUNTRY, 1'h0, 4, 32'h40CC1234, i == 6);
      check_rec(REC_COUNTRY, 1'h0, 64'h0, 1'h0);
      for (int i = 0; i < 7; i++) check_rec(REC_COUNTRY_SUB, i == 6, 64'h0, 1'h0);
      // Consumer stall fills the two-slot buffer; no byte is lost
      res_ready <= 1'h0;
      slow <= 1'h0;
      send(EXT_COMPONENT, 1'h0, 7, rows[4].bytes, 1'h1);
      repeat (8) @(posedge clk_sys);
      #1;
      check({63'h0, in_ready}, 64'h0);
      res_ready <= 1'h1;
      check_rec(REC_COMPONENT, 1'h0, rows[4].exp, 1'h1);
      repeat (4) @(posedge clk_sys);
      #1;
      check({63'h0, in_ready}, 64'h1);
      // Repeat tick spacing
      n = 0;
      while (repeat_due !== 1'h1 && n < 100) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (repeat_due !== 1'h1 && n < 100);
      check(64'(n), 64'(PERIOD));
      // Reset in mid-run clears the record outputs and raises in_ready
      @(posedge clk_sys);
      rst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      #1;
      check({rec_valid, in_ready, repeat_due, service_identifier}, {3'h2, 32'h0});
      @(posedge clk_sys);
      rst <= 1'h0;
      repeat (2) @(posedge clk_sys);
      close_out();
   end
endmodule
